// ===== core/ebwm_pkg.sv
// Purpose: Shared constants and types for the external bus write-mode block.
// Assumes: 32-bit APB register access, pclk at 20 MHz, four pclk per instruction cycle.
// Notes: Every offset, field position outside the status word, reset value and phase length lives here.
package ebwm_pkg;

	// ------------------------------------------------------------
	// Register map and fields
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_BUS_CTRL = 8'h00;
	localparam logic [7:0] OFF_CFG = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;
	localparam logic [7:0] BUS_CTRL_RESET = 8'h30; // Wait field defaults to three.
	localparam logic [7:0] BUS_CTRL_MASK = 8'hb3;
	localparam int RELEASE_BIT = 7;
	localparam int WAIT_LSB = 4;
	localparam int STYLE_LSB = 0;
	localparam logic [1:0] CFG_RESET = 2'h0;
	localparam int CFG_W8_BIT = 0;
	localparam int CFG_WAITEN_BIT = 1;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_NS = 50;
	localparam int TCY_NS = 200;
	localparam logic [3:0] TCY_CLKS = 4'(TCY_NS / CLK_NS);
	localparam logic [3:0] ADDR_CLKS = 4'h1;
	localparam logic [3:0] DATA_CLKS = TCY_CLKS - ADDR_CLKS;
	localparam logic [3:0] HALF_CLKS = TCY_CLKS >> 1;
	localparam logic [3:0] BYTE0_CLKS = HALF_CLKS - ADDR_CLKS;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		STYLE_BYTE_WRITE = 2'h0,
		STYLE_WORD_WRITE = 2'h1,
		STYLE_BYTE_SELECT = 2'h2,
		STYLE_SPARE = 2'h3
	} ebwm_style_t;

	typedef enum logic [1:0] {
		OP_FETCH = 2'h0,
		OP_TREAD = 2'h1,
		OP_TWRITE = 2'h2,
		OP_NONE = 2'h3
	} ebwm_op_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_ADDR = 3'h1,
		ST_DATA = 3'h2,
		ST_BYTE1 = 3'h3,
		ST_WAIT = 3'h4
	} ebwm_seq_t;

	typedef struct packed {
		logic [15:0] ad_out;
		logic ad_oe;
		logic [3:0] addr_hi;
		logic ale;
		logic oe_n;
		logic write_strobe_high_n;
		logic write_strobe_low_n;
		logic ce_n;
		logic upper_byte_enable_n;
		logic lower_byte_enable_n;
		logic byte_address_out;
		logic pins_as_ports;
	} ebwm_pins_t;

	typedef struct packed {
		ebwm_op_t kind;
		logic [20:0] table_pointer;
		logic [7:0] table_byte_latch;
	} ebwm_req_t;

endpackage

// ===== core/ebwm_bus.sv
// Purpose: External memory bus sequencer with 16-bit write styles and 8-bit muxed mode.
// Assumes: Core requests and power states arrive on pclk; the bus data pins do not.
// Notes: One instruction cycle is four pclk; registers sit on APB with a one-cycle access.
//
// Notes on behaviour
// - Word-write even: latch byte held, bus tri-stated.
// - Word-write even: no write strobe.
// - Word-write odd: latch high, held byte low.
// - Word-write odd: high strobe, both byte enables.
// - Word-write: byte address shows pointer LSB.
// - Byte-select: byte on both halves, high strobe.
// - Byte-select: pointer LSB drives enables, address.
// - Eight-bit width is always multiplexed.
// - Eight-bit fetch: two bytes per cycle.
// - Eight-bit: ALE, first byte, toggle, second.
// - Eight-bit writes: byte address follows pointer.
// - Chip select low per access, high asleep.
// - Slow run modes: bus follows clock.
// - Sleep and idle freeze the bus.
// - Sleep/idle force select and enables high.
// - Sleep instruction always freezes the bus.
// - Two-bit field selects the write style.
// - Wait field adds zero to three cycles.
// - Byte-write: both halves, strobe by LSB.
// - Release bit hands idle pins to ports.
`timescale 1ns/1ps

module ebwm_bus
	import ebwm_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic req_valid,
	input wire ebwm_pkg::ebwm_req_t req,
	output logic req_ready,
	output logic resp_valid,
	output logic [15:0] resp_data,
	input wire logic sleep_in,
	input wire logic idle_in,
	input wire logic [15:0] ad_in,
	output ebwm_pkg::ebwm_pins_t bus_pins
);
	import ebwm_pkg::*;

	typedef struct packed {
		ebwm_seq_t st;
		logic [3:0] cnt;
		ebwm_req_t op;
		logic [7:0] hold;
		logic [15:0] rdata;
		logic [7:0] bus_ctrl;
		logic [1:0] cfg;
		logic [15:0] sync1;
		logic [15:0] sync2;
		ebwm_pins_t pins;
		logic resp_valid;
		logic [31:0] prdata;
		logic pslverr;
	} ebwm_all_t;

	ebwm_all_t r;
	ebwm_all_t nxt;
	logic frozen;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------

	// Unused style code falls back to byte-select.
	function automatic ebwm_style_t style_of(input logic [7:0] ctrl);
		ebwm_style_t s;
		s = ebwm_style_t'(ctrl[STYLE_LSB +: 2]);
		if (s == STYLE_SPARE) begin
			s = STYLE_BYTE_SELECT;
		end
		return s;
	endfunction

	// Pins of an idle bus, either released to ports or parked inactive.
	function automatic ebwm_pins_t idle_pins(input logic release_bit);
		ebwm_pins_t p;
		p = '0;
		p.oe_n = 1'b1;
		p.write_strobe_high_n = 1'b1;
		p.write_strobe_low_n = 1'b1;
		p.ce_n = 1'b1;
		p.upper_byte_enable_n = 1'b1;
		p.lower_byte_enable_n = 1'b1;
		p.pins_as_ports = release_bit;
		return p;
	endfunction

	// Address phase: ALE high with the address driven on the shared lines.
	function automatic ebwm_pins_t addr_pins(input logic [20:0] a);
		ebwm_pins_t p;
		p = idle_pins(1'b0);
		p.ad_out = a[16:1];
		p.ad_oe = 1'b1;
		p.addr_hi = a[20:17];
		p.byte_address_out = a[0];
		p.ale = 1'b1;
		p.ce_n = 1'b0;
		return p;
	endfunction

	// Data phase levels for the captured operation; second selects the second byte slot.
	function automatic ebwm_pins_t data_pins(input ebwm_req_t o, input logic [7:0] hold,
		input ebwm_style_t s, input logic w8, input logic second);
		ebwm_pins_t p;
		logic lsb;
		p = addr_pins(o.table_pointer);
		lsb = o.table_pointer[0];
		p.ale = 1'b0;
		p.ad_oe = 1'b0;
		p.upper_byte_enable_n = 1'b0;
		p.lower_byte_enable_n = 1'b0;
		if (o.kind != OP_TWRITE) begin
			p.oe_n = 1'b0;
			if (w8 && o.kind == OP_FETCH) begin
				p.byte_address_out = second;
			end
		end else if (w8) begin
			// Only the low eight lines carry data; the upper lines keep the address.
			p.ad_out[7:0] = o.table_byte_latch;
			p.ad_oe = 1'b1;
			p.byte_address_out = lsb;
			p.write_strobe_high_n = 1'b0;
		end else begin
			unique case (s)
				STYLE_BYTE_WRITE: begin
					p.ad_out = {o.table_byte_latch, o.table_byte_latch};
					p.ad_oe = 1'b1;
					p.write_strobe_high_n = ~lsb;
					p.write_strobe_low_n = lsb;
				end
				STYLE_WORD_WRITE: begin
					// Both enables stay active; the byte address is shown but unused.
					p.byte_address_out = lsb;
					if (lsb) begin
						p.ad_out = {o.table_byte_latch, hold};
						p.ad_oe = 1'b1;
						p.write_strobe_high_n = 1'b0;
					end
				end
				default: begin
					p.ad_out = {o.table_byte_latch, o.table_byte_latch};
					p.ad_oe = 1'b1;
					p.write_strobe_high_n = 1'b0;
					p.upper_byte_enable_n = ~lsb;
					p.lower_byte_enable_n = lsb;
				end
			endcase
		end
		return p;
	endfunction

	// ------------------------------------------------------------
	// Handshake outputs
	// ------------------------------------------------------------

	// Sleep or idle stops the sequencer where it stands.
	assign frozen = sleep_in | idle_in;
	assign req_ready = (r.st == ST_IDLE) && !frozen;
	assign pready = 1'b1;
	assign prdata = r.prdata;
	assign pslverr = r.pslverr;
	assign resp_valid = r.resp_valid;
	assign resp_data = r.rdata;
	assign bus_pins = r.pins;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------

	// All bus timing counts pclk, so a slower core clock stretches every phase alike.
	always_comb begin
		logic w8;
		logic waits;
		ebwm_style_t s;
		w8 = 1'b0;
		waits = 1'b0;
		s = STYLE_BYTE_WRITE;
		nxt = r;
		nxt.resp_valid = 1'b0;
		// The sync pipe pauses with the sequencer, so a captured byte stays matched to its slot.
		if (!frozen) begin
			nxt.sync1 = ad_in;
			nxt.sync2 = r.sync1;
		end
		w8 = r.cfg[CFG_W8_BIT];
		s = style_of(r.bus_ctrl);
		waits = r.cfg[CFG_WAITEN_BIT] && (r.bus_ctrl[WAIT_LSB +: 2] != 2'h0);

		// Read data and error are prepared in the setup cycle, so they are flops.
		if (psel && !penable) begin
			nxt.pslverr = 1'b0;
			unique case (paddr)
				OFF_BUS_CTRL: nxt.prdata = {24'h0, r.bus_ctrl};
				OFF_CFG: nxt.prdata = {30'h0, r.cfg};
				OFF_STATUS: nxt.prdata = {19'h0, frozen, r.st, r.hold, 1'b0};
				default: begin
					nxt.prdata = 32'h0;
					nxt.pslverr = 1'b1;
				end
			endcase
		end
		if (psel && penable && pwrite) begin
			if (paddr == OFF_BUS_CTRL) begin
				nxt.bus_ctrl = pwdata[7:0] & BUS_CTRL_MASK;
			end
			if (paddr == OFF_CFG) begin
				nxt.cfg = pwdata[1:0];
			end
		end

		if (frozen) begin
			// Pins hold their entry levels except select and byte enables.
			nxt.pins.ce_n = 1'b1;
			nxt.pins.upper_byte_enable_n = 1'b1;
			nxt.pins.lower_byte_enable_n = 1'b1;
		end else begin
			unique case (r.st)
				ST_IDLE: begin
					nxt.pins = idle_pins(r.bus_ctrl[RELEASE_BIT]);
					if (req_valid) begin
						nxt.op = req;
						nxt.st = ST_ADDR;
						nxt.cnt = ADDR_CLKS - 4'h1;
						nxt.pins = addr_pins(req.table_pointer);
					end
				end
				ST_ADDR: begin
					nxt.pins = addr_pins(r.op.table_pointer);
					nxt.cnt = r.cnt - 4'h1;
					if (r.cnt == 4'h0) begin
						nxt.st = ST_DATA;
						nxt.cnt = (w8 && r.op.kind == OP_FETCH) ? BYTE0_CLKS - 4'h1
							: DATA_CLKS - 4'h1;
						nxt.pins = data_pins(r.op, r.hold, s, w8, 1'b0);
					end
				end
				ST_DATA: begin
					nxt.pins = data_pins(r.op, r.hold, s, w8, 1'b0);
					nxt.cnt = r.cnt - 4'h1;
					if (r.cnt == 4'h0) begin
						nxt.pins.oe_n = 1'b1;
						nxt.pins.write_strobe_high_n = 1'b1;
						nxt.pins.write_strobe_low_n = 1'b1;
						if (r.op.kind == OP_TWRITE && !w8 && s == STYLE_WORD_WRITE
							&& !r.op.table_pointer[0]) begin
							// Even half of a word write only fills the holding byte.
							nxt.hold = r.op.table_byte_latch;
						end
						if (w8) begin
							nxt.rdata = {8'h0, r.sync2[7:0]};
						end else begin
							nxt.rdata = r.sync2;
						end
						if (w8 && r.op.kind == OP_FETCH) begin
							nxt.st = ST_BYTE1;
							nxt.cnt = HALF_CLKS - 4'h1;
							nxt.pins = data_pins(r.op, r.hold, s, w8, 1'b1);
						end else if (waits && r.op.kind != OP_FETCH) begin
							nxt.st = ST_WAIT;
							nxt.cnt = 4'(r.bus_ctrl[WAIT_LSB +: 2] * TCY_CLKS) - 4'h1;
						end else begin
							nxt.st = ST_IDLE;
							nxt.resp_valid = 1'b1;
							nxt.pins = idle_pins(r.bus_ctrl[RELEASE_BIT]);
						end
					end
				end
				ST_BYTE1: begin
					// Second byte slot: the byte address has toggled high.
					nxt.pins = data_pins(r.op, r.hold, s, w8, 1'b1);
					nxt.cnt = r.cnt - 4'h1;
					if (r.cnt == 4'h0) begin
						// Byte zero has just reached the second sync flop; byte one needs
						// one more pclk, so the bus parks and a one-cycle tail collects it.
						// The unused latch field of a fetch keeps byte zero meanwhile.
						nxt.op.table_byte_latch = r.sync2[7:0];
						nxt.st = ST_WAIT;
						nxt.cnt = 4'h0;
						nxt.pins = idle_pins(r.bus_ctrl[RELEASE_BIT]);
					end
				end
				ST_WAIT: begin
					// Strobes are already off; the address stays on while memory settles.
					// A narrow fetch passes here once only to let its second byte arrive.
					if (r.op.kind != OP_FETCH) begin
						nxt.pins.ce_n = 1'b0;
						nxt.pins.upper_byte_enable_n = 1'b0;
						nxt.pins.lower_byte_enable_n = 1'b0;
					end
					nxt.cnt = r.cnt - 4'h1;
					if (r.cnt == 4'h0) begin
						if (r.op.kind == OP_FETCH) begin
							nxt.rdata = {r.sync2[7:0], r.op.table_byte_latch};
						end
						nxt.st = ST_IDLE;
						nxt.resp_valid = 1'b1;
						nxt.pins = idle_pins(r.bus_ctrl[RELEASE_BIT]);
					end
				end
				default: begin
					nxt.st = ST_IDLE;
					nxt.pins = idle_pins(r.bus_ctrl[RELEASE_BIT]);
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------

	// The sync2 field is the only reader of sync1, keeping the crossing clean.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
			r.st <= ST_IDLE;
			r.op.kind <= OP_NONE;
			r.bus_ctrl <= BUS_CTRL_RESET;
			r.cfg <= CFG_RESET;
			r.pins.oe_n <= 1'b1;
			r.pins.write_strobe_high_n <= 1'b1;
			r.pins.write_strobe_low_n <= 1'b1;
			r.pins.ce_n <= 1'b1;
			r.pins.upper_byte_enable_n <= 1'b1;
			r.pins.lower_byte_enable_n <= 1'b1;
		end else begin
			r <= nxt;
		end
	end

endmodule

// ===== testbench/ebwm_bus_sva.sv
// Purpose: Port checker for the external bus write-mode sequencer.
// Assumes: Style and width are mirrored from APB writes.
// Notes: Cycle offsets follow the hand-over walk of each transfer.
`timescale 1ns/1ps
module ebwm_bus_sva
	import ebwm_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic req_valid,
	input wire ebwm_pkg::ebwm_req_t req,
	input wire logic req_ready,
	input wire logic sleep_in,
	input wire logic idle_in,
	input wire ebwm_pkg::ebwm_pins_t bus_pins
);
	// ----------------------------------------
	// Mode mirror and properties
	// ----------------------------------------
	logic [1:0] sty_r;
	logic w8_r;
	wire go = req_valid && req_ready;
	wire tw = go && req.kind == OP_TWRITE && !w8_r;
	wire lo = req.table_pointer[0];
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// The mirror lets each style or width property know which write style and width are live.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sty_r <= BUS_CTRL_RESET[1:0];
			w8_r <= 1'b0;
		end else if (psel && penable && pwrite && paddr == OFF_BUS_CTRL) begin
			sty_r <= pwdata[1:0];
		end else if (psel && penable && pwrite && paddr == OFF_CFG) begin
			w8_r <= pwdata[CFG_W8_BIT];
		end
	end
	property p_sel; go |=> bus_pins.ale && !bus_pins.ce_n; endproperty
	a_sel: assert property (p_sel) else $error("no select at access");
	property p_frz; sleep_in || idle_in |=> bus_pins.ce_n && bus_pins.upper_byte_enable_n
		&& bus_pins.lower_byte_enable_n; endproperty
	a_frz: assert property (p_frz) else $error("select not forced high");
	property p_hold; sleep_in || idle_in |=> $stable(bus_pins.ad_out) && $stable(bus_pins.oe_n)
		&& $stable(bus_pins.write_strobe_high_n); endproperty
	a_hold: assert property (p_hold) else $error("bus moved while frozen");
	property p_rdy; sleep_in || idle_in |-> !req_ready ##1 $stable(bus_pins.ale); endproperty
	a_rdy: assert property (p_rdy) else $error("request taken asleep");
	property p_ev; tw && sty_r == STYLE_WORD_WRITE && !lo |-> ##2 (!bus_pins.ad_oe
		&& bus_pins.write_strobe_high_n && bus_pins.write_strobe_low_n)[*3]; endproperty
	a_ev: assert property (p_ev) else $error("even word write drove bus");
	property p_od; tw && sty_r == STYLE_WORD_WRITE && lo |-> ##2 !bus_pins.write_strobe_high_n
		&& !bus_pins.upper_byte_enable_n && !bus_pins.lower_byte_enable_n
		&& bus_pins.ad_out[15:8] == $past(req.table_byte_latch, 2); endproperty
	a_od: assert property (p_od) else $error("odd word write wrong");
	property p_bs; tw && sty_r[1] |-> ##2 bus_pins.ad_out[15:8] == bus_pins.ad_out[7:0]
		&& !bus_pins.write_strobe_high_n && bus_pins.write_strobe_low_n
		&& bus_pins.lower_byte_enable_n == $past(lo, 2)
		&& bus_pins.upper_byte_enable_n == !$past(lo, 2); endproperty
	a_bs: assert property (p_bs) else $error("byte select write wrong");
	property p_bw; tw && sty_r == STYLE_BYTE_WRITE |-> ##2
		bus_pins.write_strobe_low_n == $past(lo, 2)
		&& bus_pins.write_strobe_high_n == !$past(lo, 2); endproperty
	a_bw: assert property (p_bw) else $error("byte write strobe wrong");
	property p_ba; go && req.kind == OP_TWRITE |=>
		bus_pins.byte_address_out == $past(lo); endproperty
	a_ba: assert property (p_ba) else $error("byte address wrong");
	property p_f8; go && w8_r && req.kind == OP_FETCH |-> ##2 !bus_pins.oe_n
		&& !bus_pins.byte_address_out ##1 !bus_pins.oe_n && bus_pins.byte_address_out; endproperty
	a_f8: assert property (p_f8) else $error("narrow fetch order wrong");
	c_bs: cover property (tw && sty_r[1]);
	c_f8: cover property (go && w8_r);
	c_id: cover property (idle_in && !req_ready);
endmodule
bind ebwm_bus ebwm_bus_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.req_valid, .req, .req_ready, .sleep_in, .idle_in, .bus_pins);

// ===== testbench/ebwm_mem.sv
// Purpose: Behavioural external memory on the far side of the bus.
// Assumes: Word address is caught while the latch enable is high.
// Notes: Only 256 bytes are modelled; pointers stay inside them.
`timescale 1ns/1ps
module ebwm_mem
	import ebwm_pkg::*;
(
	input wire logic pclk,
	input wire ebwm_pkg::ebwm_pins_t pins,
	input wire logic w8,
	input wire logic two_chips,
	output logic [15:0] ad_in
);
	// ----------------------------------------
	// Storage and pin behaviour
	// ----------------------------------------
	logic [7:0] mem [0:255];
	logic [6:0] wa;
	logic [15:0] last = 16'h0000;
	initial foreach (mem[i]) mem[i] = 8'h00;
	// Lanes follow the wiring: one byte part, two byte parts on separate strobes,
	// or a word part whose enables pick the lanes, as a byte-selectable SRAM does.
	always @(posedge pclk) begin
		if (pins.ale) begin
			wa <= pins.ad_out[6:0];
		end
		if (!pins.oe_n) begin
			last <= ad_in;
		end
		if (w8) begin
			if (!pins.write_strobe_high_n) begin
				mem[{wa, pins.byte_address_out}] <= pins.ad_out[7:0];
			end
		end else if (two_chips) begin
			if (!pins.write_strobe_high_n) begin
				mem[{wa, 1'b1}] <= pins.ad_out[15:8];
			end
			if (!pins.write_strobe_low_n) begin
				mem[{wa, 1'b0}] <= pins.ad_out[7:0];
			end
		end else if (!pins.write_strobe_high_n) begin
			if (!pins.upper_byte_enable_n) begin
				mem[{wa, 1'b1}] <= pins.ad_out[15:8];
			end
			if (!pins.lower_byte_enable_n) begin
				mem[{wa, 1'b0}] <= pins.ad_out[7:0];
			end
		end
	end
	// Released lines show the inverse of their last value, never a helpful copy.
	always_comb begin
		if (pins.oe_n) ad_in = ~last;
		else if (w8) ad_in = {~last[15:8], mem[{wa, pins.byte_address_out}]};
		else ad_in = {mem[{wa, 1'b1}], mem[{wa, 1'b0}]};
	end
endmodule

// ===== testbench/tb_top.sv
// Purpose: Self-checking bench for the external bus write-mode sequencer.
// Assumes: Register map and timing constants from the package.
// Notes: Expected memory is kept in a byte array written from the stimulus.
`timescale 1ns/1ps
module tb_top;
	import ebwm_pkg::*;
	// ----------------------------------------
	// Stimulus, model and checks
	// ----------------------------------------
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, req_valid = 0;
	logic sleep_in = 0, idle_in = 0, w8 = 0, pready, pslverr, req_ready, resp_valid, er;
	logic two_chips = 0;
	logic [7:0] paddr = 8'h00, a, b0, b1;
	logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'ha5d238fd;
	logic [15:0] resp_data, ad_in, rv;
	ebwm_req_t req = '0;
	ebwm_pins_t pins;
	logic [7:0] exp [0:255];
	int err_total = 0, num_checks = 0, n, n0;
	// Clock toggles each half period.
	always #(CLK_NS / 2) pclk = ~pclk;
	ebwm_bus uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .req_valid, .req, .req_ready, .resp_valid, .resp_data, .sleep_in, .idle_in,
		.ad_in, .bus_pins(pins));
	ebwm_mem mem (.pclk, .pins, .w8, .two_chips, .ad_in);
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		num_checks++;
		if (got !== want) begin
			err_total++;
			$display("mismatch at %0t got %h want %h", $time, got, want);
		end
	endtask
	task automatic wrap_up();
		if (err_total == 0 && num_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// A request is held until an edge finds the block ready, then cycles are counted.
	task automatic op(input ebwm_op_t k, input logic [7:0] p, input logic [7:0] d);
		@(posedge pclk);
		req_valid <= 1'b1;
		req <= '{k, 21'(p), d};
		@(negedge pclk);
		while (req_ready !== 1'b1) @(negedge pclk);
		@(posedge pclk);
		req_valid <= 1'b0;
		n = 0;
		do begin
			@(negedge pclk);
			n++;
		end while (resp_valid !== 1'b1);
		rv = resp_data;
	endtask
	// Watchdog cuts a hang short.
	initial begin
		#(CLK_NS * 5000);
		err_total++;
		wrap_up();
	end
	initial begin
		foreach (exp[i]) exp[i] = 8'h00;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, OFF_BUS_CTRL, 32'h0);
		chk(rd, 32'(BUS_CTRL_RESET));
		apb(1'b0, 8'h0c, 32'h0);
		chk(32'(er), 32'h1);
		apb(1'b1, OFF_BUS_CTRL, 32'h31);
		for (int i = 0; i < 4; i++) begin
			a = rnd() & 8'hfe;
			b0 = rnd();
			b1 = rnd();
			op(OP_TWRITE, a, b0);
			apb(1'b0, OFF_STATUS, 32'h0);
			chk(rd, {23'h0, b0, 1'b0});
			op(OP_TWRITE, a | 8'h01, b1);
			exp[a] = b0;
			exp[a | 8'h01] = b1;
			op(OP_TREAD, a, 8'h00);
			chk(32'(rv), {16'h0, b1, b0});
		end
		for (int s = 2; s < 4; s++) begin
			apb(1'b1, OFF_BUS_CTRL, 32'(8'h30 | s));
			for (int i = 0; i < 4; i++) begin
				b0 = rnd();
				a = rnd();
				op(OP_TWRITE, a, b0);
				exp[a] = b0;
				op(OP_TREAD, a, 8'h00);
				chk(32'(rv), {16'h0, exp[a | 8'h01], exp[a & 8'hfe]});
			end
		end
		a = a & 8'hfe;
		apb(1'b1, OFF_CFG, 32'h2);
		for (int c = 0; c < 4; c++) begin
			apb(1'b1, OFF_BUS_CTRL, 32'(8'h02 | (c << WAIT_LSB)));
			op(OP_TREAD, a, 8'h00);
			if (c == 0) n0 = n;
			chk(32'(n - n0), 32'(TCY_CLKS * c));
		end
		apb(1'b1, OFF_CFG, 32'h1);
		w8 <= 1'b1;
		op(OP_FETCH, a, 8'h00);
		chk(32'(rv), {16'h0, exp[a | 8'h01], exp[a]});
		apb(1'b1, OFF_CFG, 32'h0);
		w8 <= 1'b0;
		for (int j = 0; j < 2; j++) begin
			fork
				op(OP_TREAD, a, 8'h00);
				begin
					repeat (3) @(posedge pclk);
					{idle_in, sleep_in} <= 2'(1 << j);
					repeat (3) @(posedge pclk);
					@(negedge pclk);
					chk(32'(pins.ce_n & pins.upper_byte_enable_n & pins.lower_byte_enable_n), 32'h1);
					@(posedge pclk);
					{idle_in, sleep_in} <= 2'h0;
				end
			join
			chk(32'(rv), {16'h0, exp[a | 8'h01], exp[a]});
		end
		apb(1'b1, OFF_BUS_CTRL, 32'h80);
		repeat (2) @(negedge pclk);
		chk(32'(pins.pins_as_ports), 32'h1);
		op(OP_TREAD, a, 8'h00);
		chk(32'(rv), {16'h0, exp[a | 8'h01], exp[a]});
		apb(1'b1, OFF_BUS_CTRL, 32'h30);
		two_chips <= 1'b1;
		b0 = rnd();
		b1 = rnd();
		op(OP_TWRITE, a, b0);
		op(OP_TWRITE, a | 8'h01, b1);
		exp[a] = b0;
		exp[a | 8'h01] = b1;
		op(OP_TREAD, a, 8'h00);
		chk(32'(rv), {16'h0, b1, b0});
		wrap_up();
	end
endmodule
